/* design/ism_device.sv */
// Serial port: 7-bit slave receiver plus master acknowledge and stop sequences
module ism_device (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  ism_link_if.device link,
  input wire logic [ism_pkg::ADDR_W-1:0] sw_addr_in,
  input wire logic [ism_pkg::DATA_W-1:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [ism_pkg::DATA_W-1:0] sw_rdata_out
);
  import ism_pkg::*;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0] serial_shift_buffer;
  logic [5:0] serial_status_reg;
  logic [2:0] serial_control_one;
  logic [3:0] serial_control_two;
  logic [4:0] serial_control_three;
  logic [7:0] baud_reload;
  logic [6:0] own_addr;
  ism_slave_t sstate;
  ism_master_t mstate;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic ack_drive;
  logic hold_ack;
  logic stretch;
  logic [7:0] brg;
  logic mst_scl_low;
  logic mst_sda_low;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction

  ism_sync u_scl (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .pin_in(link.scl), .level_out(scl_s));
  ism_sync u_sda (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .pin_in(link.sda), .level_out(sda_s));

  // ----------------------------------------
  // Bus events and slave decisions
  // ----------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic active;
  logic byte_done;
  logic ack_done;
  logic is_addr;
  logic take;
  logic ovf_now;
  logic hold_now;
  logic acked;
  logic load_buf;
  logic brg_zero;
  logic ack_end;
  logic pen_end;
  logic mstop_seen;
  logic wr_buf;
  logic write_collision_flag_now;
  logic flag_set;
  logic ckp_clr;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  assign active = (sstate != SL_IDLE);
  assign byte_done = scl_fall & active & (bitcnt == 4'h7);
  assign ack_done = scl_fall & active & (bitcnt == 4'h8);
  assign is_addr = (sstate == SL_ADDR);
  assign take = byte_done & (~is_addr | ((shreg[7:1] == own_addr) & ~shreg[0]));
  assign ovf_now = serial_status_reg[ST_BF] | serial_control_one[C1_ROVF];
  assign load_buf = take & (~ovf_now | serial_control_three[C3_BUFFER_OVERWRITE_ENABLE]);
  assign hold_now = take & (is_addr ? serial_control_three[C3_ADDRESS_HOLD_ENABLE] : serial_control_three[C3_DATA_HOLD_ENABLE]);
  assign acked = ack_done & ack_drive;
  assign brg_zero = (brg == 8'h00);
  assign ack_end = (mstate == M_ACK_HI) & brg_zero;
  assign pen_end = (mstate == M_STP_END) & brg_zero;
  assign mstop_seen = (mstate == M_STP_REL) & sda_s & scl_s;
  assign wr_buf = sw_wr_in & hit(sw_addr_in, REG_BUFFER);
  assign write_collision_flag_now = wr_buf & (mstate != M_IDLE);
  // Hold events flag before the acknowledge, others after it
  assign flag_set = (start_det & serial_control_three[C3_SCIE])
                  | (stop_det & serial_control_three[C3_PCIE])
                  | hold_now | acked | pen_end;
  assign ckp_clr = hold_now | (acked & serial_control_two[C2_SEN]);

  // Line history for edge detection
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ----------------------------------------
  // Slave receiver
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sstate <= SL_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ack_drive <= 1'b0;
      hold_ack <= 1'b0;
    end else if (start_det) begin
      sstate <= SL_ADDR;
      bitcnt <= 4'hF; // Start's own SCL fall wraps the count to zero
      ack_drive <= 1'b0;
      hold_ack <= 1'b0;
    end else if (stop_det) begin
      sstate <= SL_IDLE;
      ack_drive <= 1'b0;
      hold_ack <= 1'b0;
    end else if (active) begin
      if (scl_rise && bitcnt < 4'h8) begin
        shreg <= {shreg[6:0], sda_s};
      end
      if (byte_done) begin
        bitcnt <= 4'h8;
        hold_ack <= hold_now;
        ack_drive <= take & ~hold_now & (~ovf_now | serial_control_three[C3_BUFFER_OVERWRITE_ENABLE]);
        if (!take) begin
          sstate <= SL_IDLE;
        end
      end else if (ack_done) begin
        bitcnt <= 4'h0;
        ack_drive <= 1'b0;
        hold_ack <= 1'b0;
        sstate <= ack_drive ? SL_DATA : SL_IDLE;
      end else if (hold_ack) begin
        ack_drive <= ~serial_control_two[C2_ACKNOWLEDGE_DATA_BIT];
      end else if (scl_fall) begin
        bitcnt <= bitcnt + 4'h1;
      end
    end
  end

  // Clock stretch until software sets the release bit
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      stretch <= 1'b0;
    end else if (ckp_clr) begin
      stretch <= 1'b1;
    end else if (serial_control_one[C1_CKP]) begin
      stretch <= 1'b0;
    end
  end

  // ----------------------------------------
  // Master acknowledge and stop sequences
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mstate <= M_IDLE;
      brg <= 8'h00;
      mst_scl_low <= 1'b0;
      mst_sda_low <= 1'b0;
    end else begin
      case (mstate)
        M_IDLE: begin
          brg <= baud_reload;
          if (serial_control_two[C2_ACKNOWLEDGE_SEQUENCE_ENABLE]) begin
            mst_scl_low <= 1'b1;
            mst_sda_low <= ~serial_control_two[C2_ACKNOWLEDGE_DATA_BIT];
            mstate <= M_ACK_LO;
          end else if (serial_control_two[C2_PEN]) begin
            mst_sda_low <= 1'b1;
            mstate <= M_STP_SDA;
          end
        end
        M_ACK_LO: begin
          if (brg_zero) begin
            mst_scl_low <= 1'b0;
            mstate <= M_ACK_REL;
          end else begin
            brg <= brg - 8'h01;
          end
        end
        M_ACK_REL: begin
          if (scl_s) begin
            brg <= baud_reload;
            mstate <= M_ACK_HI;
          end
        end
        M_ACK_HI: begin
          if (brg_zero) begin
            mst_scl_low <= 1'b1;
            mst_sda_low <= 1'b0;
            mstate <= M_IDLE;
          end else begin
            brg <= brg - 8'h01;
          end
        end
        M_STP_SDA: begin
          if (!sda_s) begin
            brg <= baud_reload;
            mstate <= M_STP_CNT;
          end
        end
        M_STP_CNT: begin
          if (brg_zero) begin
            mst_scl_low <= 1'b0;
            brg <= baud_reload;
            mstate <= M_STP_SCL;
          end else begin
            brg <= brg - 8'h01;
          end
        end
        M_STP_SCL: begin
          if (brg_zero) begin
            mst_sda_low <= 1'b0;
            mstate <= M_STP_REL;
          end else begin
            brg <= brg - 8'h01;
          end
        end
        M_STP_REL: begin
          if (mstop_seen) begin
            brg <= baud_reload;
            mstate <= M_STP_END;
          end
        end
        M_STP_END: begin
          if (brg_zero) begin
            mstate <= M_IDLE;
          end else begin
            brg <= brg - 8'h01;
          end
        end
        default: begin
          mstate <= M_IDLE;
        end
      endcase
    end
  end

  // Pin drivers, low only
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      link.dev_scl_o <= 1'b0;
      link.dev_sda_o <= 1'b0;
      link.dev_scl_oe <= 1'b0;
      link.dev_sda_oe <= 1'b0;
    end else begin
      link.dev_scl_o <= 1'b0;
      link.dev_sda_o <= 1'b0;
      link.dev_scl_oe <= stretch | mst_scl_low;
      link.dev_sda_oe <= ack_drive | mst_sda_low;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      serial_shift_buffer <= 8'h00;
      serial_status_reg <= 6'h00;
    end else begin
      if (load_buf) begin
        serial_shift_buffer <= shreg;
      end else if (wr_buf && !write_collision_flag_now) begin
        serial_shift_buffer <= sw_wdata_in;
      end
      if (load_buf) begin
        serial_status_reg[ST_BF] <= 1'b1;
      end else if (sw_rd_in && hit(sw_addr_in, REG_BUFFER)) begin
        serial_status_reg[ST_BF] <= 1'b0;
      end
      if (take && is_addr) begin
        serial_status_reg[ST_RW] <= shreg[0];
      end
      if (start_det) begin
        serial_status_reg[ST_START] <= 1'b1;
        serial_status_reg[ST_STOP] <= 1'b0;
      end else if (stop_det || mstop_seen) begin
        serial_status_reg[ST_START] <= 1'b0;
        serial_status_reg[ST_STOP] <= 1'b1;
      end
      if (flag_set) begin
        serial_status_reg[ST_FLAG] <= 1'b1;
      end else if (sw_wr_in && hit(sw_addr_in, REG_STATUS)) begin
        serial_status_reg[ST_FLAG] <= sw_wdata_in[ST_FLAG];
      end
      if (hold_now) begin
        serial_status_reg[ST_ACKNOWLEDGE_TIME_STATUS] <= 1'b1;
      end else if (ack_done) begin
        serial_status_reg[ST_ACKNOWLEDGE_TIME_STATUS] <= 1'b0;
      end
    end
  end

  // Control registers; hardware set or clear beats software in control one, a software write beats hardware clear in control two
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      serial_control_one <= {2'b00, CKP_RST};
      serial_control_two <= 4'h0;
      serial_control_three <= 5'h00;
      baud_reload <= BAUD_RST;
      own_addr <= OWN_ADDR_RST;
    end else begin
      if (ckp_clr) begin
        serial_control_one[C1_CKP] <= 1'b0;
      end else if (sw_wr_in && hit(sw_addr_in, REG_CTRL1)) begin
        serial_control_one[C1_CKP] <= sw_wdata_in[C1_CKP];
      end
      if (take && ovf_now) begin
        serial_control_one[C1_ROVF] <= 1'b1;
      end else if (sw_wr_in && hit(sw_addr_in, REG_CTRL1)) begin
        serial_control_one[C1_ROVF] <= sw_wdata_in[C1_ROVF];
      end
      if (write_collision_flag_now) begin
        serial_control_one[C1_WRITE_COLLISION_FLAG] <= 1'b1;
      end else if (sw_wr_in && hit(sw_addr_in, REG_CTRL1)) begin
        serial_control_one[C1_WRITE_COLLISION_FLAG] <= sw_wdata_in[C1_WRITE_COLLISION_FLAG];
      end
      if (sw_wr_in && hit(sw_addr_in, REG_CTRL2)) begin
        serial_control_two <= sw_wdata_in[3:0];
      end else begin
        if (ack_end) begin
          serial_control_two[C2_ACKNOWLEDGE_SEQUENCE_ENABLE] <= 1'b0;
        end
        if (pen_end) begin
          serial_control_two[C2_PEN] <= 1'b0;
        end
      end
      if (sw_wr_in && hit(sw_addr_in, REG_CTRL3)) begin
        serial_control_three <= sw_wdata_in[4:0];
      end
      if (sw_wr_in && hit(sw_addr_in, REG_BAUD)) begin
        baud_reload <= sw_wdata_in;
      end
      if (sw_wr_in && hit(sw_addr_in, REG_OWN)) begin
        own_addr <= sw_wdata_in[6:0];
      end
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !sw_rd_in) begin
      sw_rdata_out <= 8'h00;
    end else begin
      case (sw_addr_in)
        REG_STATUS: sw_rdata_out <= {2'b00, serial_status_reg};
        REG_BUFFER: sw_rdata_out <= serial_shift_buffer;
        REG_CTRL1: sw_rdata_out <= {5'h00, serial_control_one};
        REG_CTRL2: sw_rdata_out <= {4'h0, serial_control_two};
        REG_CTRL3: sw_rdata_out <= {3'h0, serial_control_three};
        REG_BAUD: sw_rdata_out <= baud_reload;
        REG_OWN: sw_rdata_out <= {1'b0, own_addr};
        default: sw_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule

/* design/ism_link_if.sv */
// Open-drain bus joining the two ends
interface ism_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic far_scl_o;
  logic far_scl_oe;
  logic far_sda_o;
  logic far_sda_oe;
  logic scl;
  logic sda;
  // Wired-and with pull-up
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (far_scl_oe & ~far_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (far_sda_oe & ~far_sda_o));
  modport device (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
  modport partner (output far_scl_o, far_scl_oe, far_sda_o, far_sda_oe, input scl, sda);
endinterface

/* design/ism_partner.sv */
// Far end: bus master making SCL from its own clock, honouring stretch
module ism_partner (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  ism_link_if.partner link,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_in,
  input wire logic [ism_pkg::DATA_W-1:0] byte_in,
  output logic busy_out,
  output logic done_out,
  output logic nack_out
);
  import ism_pkg::*;
  ism_far_t state;
  logic scl_s;
  logic sda_s;
  logic scl_low;
  logic sda_low;
  logic [7:0] hc;
  logic [7:0] shr;
  logic [3:0] bitn;

  ism_sync u_scl (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .pin_in(link.scl), .level_out(scl_s));
  ism_sync u_sda (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .pin_in(link.sda), .level_out(sda_s));

  // Pin drivers, low only
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      link.far_scl_o <= 1'b0;
      link.far_sda_o <= 1'b0;
      link.far_scl_oe <= 1'b0;
      link.far_sda_oe <= 1'b0;
    end else begin
      link.far_scl_o <= 1'b0;
      link.far_sda_o <= 1'b0;
      link.far_scl_oe <= scl_low;
      link.far_sda_oe <= sda_low;
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state <= P_IDLE;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      hc <= 8'h00;
      shr <= 8'h00;
      bitn <= 4'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        P_IDLE: begin
          hc <= LOW_CYC;
          if (cmd_valid_in) begin
            case (cmd_in)
              CMD_START: begin
                sda_low <= 1'b0; // Released first, falls later under high SCL
                nack_out <= 1'b0;
                busy_out <= 1'b1;
                state <= P_START;
              end
              CMD_WRITE: begin
                if (!nack_out) begin
                  shr <= byte_in;
                  bitn <= 4'h0;
                  sda_low <= ~byte_in[7];
                  busy_out <= 1'b1;
                  state <= P_LOW;
                end
              end
              CMD_STOP: begin
                sda_low <= 1'b1;
                busy_out <= 1'b1;
                state <= P_STOP;
              end
              default: begin
              end
            endcase
          end
        end
        P_START: begin
          // Release a held clock first so a repeated start sees SCL high
          if (scl_low) begin
            if (hc != 8'h00) begin
              hc <= hc - 8'h01;
            end else begin
              scl_low <= 1'b0;
              hc <= HALF_CYC;
            end
          end else if (!scl_s) begin
            hc <= HALF_CYC;
          end else if (hc != 8'h00) begin
            hc <= hc - 8'h01;
          end else if (!sda_low) begin
            sda_low <= 1'b1; // SDA falls under a high SCL
            hc <= HALF_CYC;
          end else begin
            scl_low <= 1'b1;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state <= P_IDLE;
          end
        end
        P_LOW: begin
          if (hc != 8'h00) begin
            hc <= hc - 8'h01;
          end else begin
            scl_low <= 1'b0;
            hc <= HALF_CYC;
            state <= P_HIGH;
          end
        end
        P_HIGH: begin
          if (!scl_s) begin
            hc <= HALF_CYC;
          end else if (hc != 8'h00) begin
            hc <= hc - 8'h01;
          end else begin
            scl_low <= 1'b1;
            hc <= LOW_CYC;
            if (bitn == 4'h8) begin
              nack_out <= sda_s;
              sda_low <= 1'b0;
              busy_out <= 1'b0;
              done_out <= 1'b1;
              state <= P_IDLE;
            end else begin
              sda_low <= (bitn == 4'h7) ? 1'b0 : ~shr[6];
              shr <= {shr[6:0], 1'b0};
              bitn <= bitn + 4'h1;
              state <= P_LOW;
            end
          end
        end
        P_STOP: begin
          if (scl_low) begin
            if (hc != 8'h00) begin
              hc <= hc - 8'h01;
            end else begin
              scl_low <= 1'b0;
              hc <= HALF_CYC;
            end
          end else if (!scl_s) begin
            hc <= HALF_CYC;
          end else if (hc != 8'h00) begin
            hc <= hc - 8'h01;
          end else begin
            sda_low <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state <= P_IDLE;
          end
        end
        default: begin
          state <= P_IDLE;
        end
      endcase
    end
  end
endmodule

/* design/ism_pkg.sv */
package ism_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Register indices
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_BUFFER = 3'h1;
  localparam logic [2:0] REG_CTRL1 = 3'h2;
  localparam logic [2:0] REG_CTRL2 = 3'h3;
  localparam logic [2:0] REG_CTRL3 = 3'h4;
  localparam logic [2:0] REG_BAUD = 3'h5;
  localparam logic [2:0] REG_OWN = 3'h6;
  // Status bits
  localparam int ST_BF = 0;
  localparam int ST_RW = 1;
  localparam int ST_START = 2;
  localparam int ST_STOP = 3;
  localparam int ST_FLAG = 4;
  localparam int ST_ACKNOWLEDGE_TIME_STATUS = 5;
  // Control one bits
  localparam int C1_CKP = 0;
  localparam int C1_ROVF = 1;
  localparam int C1_WRITE_COLLISION_FLAG = 2;
  // Control two bits
  localparam int C2_SEN = 0;
  localparam int C2_ACKNOWLEDGE_DATA_BIT = 1;
  localparam int C2_ACKNOWLEDGE_SEQUENCE_ENABLE = 2;
  localparam int C2_PEN = 3;
  // Control three bits
  localparam int C3_DATA_HOLD_ENABLE = 0;
  localparam int C3_ADDRESS_HOLD_ENABLE = 1;
  localparam int C3_BUFFER_OVERWRITE_ENABLE = 2;
  localparam int C3_SCIE = 3;
  localparam int C3_PCIE = 4;
  // Reset values
  localparam logic [7:0] BAUD_RST = 8'h04;
  localparam logic [6:0] OWN_ADDR_RST = 7'h2A;
  localparam logic CKP_RST = 1'b1;
  // Timing of the far end clock maker
  localparam int SYS_CLK_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam logic [7:0] HALF_CYC = 8'((LINK_PERIOD_NS / 2) / SYS_CLK_NS);
  // Far end low phase outlasts the slave's pin-to-pin reaction
  localparam logic [7:0] LOW_CYC = 8'h0C;
  // Far end commands
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  typedef enum logic [2:0] {
    SL_IDLE = 3'b001,
    SL_ADDR = 3'b010,
    SL_DATA = 3'b100
  } ism_slave_t;
  typedef enum logic [8:0] {
    M_IDLE = 9'h001,
    M_ACK_LO = 9'h002,
    M_ACK_REL = 9'h004,
    M_ACK_HI = 9'h008,
    M_STP_SDA = 9'h010,
    M_STP_CNT = 9'h020,
    M_STP_SCL = 9'h040,
    M_STP_REL = 9'h080,
    M_STP_END = 9'h100
  } ism_master_t;
  typedef enum logic [4:0] {
    P_IDLE = 5'h01,
    P_START = 5'h02,
    P_LOW = 5'h04,
    P_HIGH = 5'h08,
    P_STOP = 5'h10
  } ism_far_t;
endpackage

/* design/ism_sync.sv */
// Three-stage pin synchroniser; level moves once stages two and three agree
module ism_sync (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_out <= s3;
      end
    end
  end
endmodule

/* tb/ism_link_monitor.sv */
module ism_link_monitor (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic far_scl_o,
  input wire logic far_scl_oe,
  input wire logic far_sda_o,
  input wire logic far_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);
  // ----
  // Bus checks
  // ----
  // Open-drain ends only ever pull low
  AST_OPEN_DRAIN: assert property (!dev_scl_o && !dev_sda_o && !far_scl_o && !far_sda_o)
    else $error("pin driven high");
  AST_NO_FALSE_START: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("sda pulled under high scl");
  AST_NO_FALSE_STOP: assert property ($fell(dev_sda_oe) && scl |-> $past(scl, 4))
    else $error("sda released under fresh scl");
  AST_RST_FREE: assert property ($fell(srst_in) |-> !(dev_scl_oe || dev_sda_oe || far_scl_oe || far_sda_oe))
    else $error("bus not free after reset");
  // SCL hold and release phases last at least four cycles, SDA hold at least three
  AST_SCL_LOW_MIN: assert property ($rose(dev_scl_oe) |-> dev_scl_oe [*4])
    else $error("scl pull too short");
  AST_SCL_HIGH_MIN: assert property ($fell(dev_scl_oe) |-> !dev_scl_oe [*4])
    else $error("scl release too short");
  AST_SDA_HOLD_MIN: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*3])
    else $error("sda pull too short");
  AST_FAR_WAITS: assert property ($rose(far_scl_oe) |-> $past(scl) && $past(scl, 2))
    else $error("far end ignored stretch");
  // Main scenarios
  cover property ($rose(dev_scl_oe) && !far_scl_oe);
  cover property ($rose(dev_sda_oe));
  cover property ($fell(dev_sda_oe) && scl);
endmodule

/* tb/testbench.sv */
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ism_pkg::*;
  logic sys_clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic [ADDR_W-1:0] sw_addr = 3'h0;
  logic [DATA_W-1:0] sw_wdata = 8'h00;
  logic sw_wr = 1'h0;
  logic sw_rd = 1'h0;
  logic [DATA_W-1:0] sw_rdata;
  logic cmd_valid = 1'h0;
  logic [1:0] cmd = 2'h0;
  logic [7:0] cmd_byte = 8'h00;
  logic busy;
  logic done;
  logic nack;
  logic [7:0] rv;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h04, 8'h2A, 8'h00};
  int num_errors = 0;
  int tests_run = 0;
  int n_done = 0;
  int want = 0;
  ism_link_if link ();
  ism_device u_ism_device (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .link(link.device), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata));
  ism_partner u_ism_partner (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .link(link.partner),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .byte_in(cmd_byte), .busy_out(busy), .done_out(done), .nack_out(nack));
  ism_link_monitor u_ism_link_monitor (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .far_scl_o(link.far_scl_o), .far_scl_oe(link.far_scl_oe),
    .far_sda_o(link.far_sda_o), .far_sda_oe(link.far_sda_oe), .scl(link.scl), .sda(link.sda));
  // ----
  // Clock and helpers
  // ----
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // Counts far end completions so a short pulse is never missed
  always @(posedge sys_clk_in) begin
    if (done === 1'h1) begin
      n_done <= n_done + 1;
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    num_errors++;
    $display("unexpected wait_limit exp event got none");
    complete_run();
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge sys_clk_in);
    sw_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk_in);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge sys_clk_in);
    sw_rd <= 1'h0;
    #1;
    rv = sw_rdata;
  endtask
  // Reads a register until one bit shows the wanted value
  task automatic poll(input logic [2:0] a, input int b, input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      rd(a);
      if (rv[b] === v) break;
    end
    if (i == 400) give_up();
  endtask
  task automatic send(input logic [1:0] c, input logic [7:0] b);
    int i;
    for (i = 0; i < 400 && busy !== 1'h0; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    if (i == 400) give_up();
    want = n_done + 1;
    @(posedge sys_clk_in);
    cmd_valid <= 1'h1;
    cmd <= c;
    cmd_byte <= b;
    @(posedge sys_clk_in);
    cmd_valid <= 1'h0;
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 4000 && n_done < want; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    if (i == 4000) give_up();
  endtask
  task automatic xfer(input logic [1:0] c, input logic [7:0] b);
    send(c, b);
    wait_done();
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'h0;
    wr(3'h7, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      rd(3'(k));
      `CHK("reset_value", rst_tab[k], rv)
    end
    $display("test registers finished");
    wr(REG_CTRL3, 8'h18);
    xfer(CMD_START, 8'h00);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    `CHK("start_seen", 1'h1, rv[ST_START])
    wr(REG_STATUS, 8'h00);
    xfer(CMD_WRITE, 8'h54);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    `CHK("addr_rx", 3'h2, {rv[ST_RW], rv[ST_BF], nack})
    wr(REG_STATUS, 8'h00);
    rd(REG_BUFFER);
    `CHK("addr_byte", 8'h54, rv)
    rd(REG_STATUS);
    `CHK("full_flag_clr", 2'h0, {rv[ST_BF], rv[ST_FLAG]})
    xfer(CMD_WRITE, 8'hA5);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    rd(REG_BUFFER);
    `CHK("data_byte", 8'hA5, rv)
    wr(REG_STATUS, 8'h00);
    xfer(CMD_STOP, 8'h00);
    poll(REG_STATUS, ST_STOP, 1'h1);
    `CHK("stop_int", 1'h1, rv[ST_FLAG])
    $display("test reception finished");
    wr(REG_CTRL3, 8'h00);
    wr(REG_STATUS, 8'h00);
    xfer(CMD_START, 8'h00);
    xfer(CMD_WRITE, 8'h54);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    wr(REG_STATUS, 8'h00);
    xfer(CMD_START, 8'h00);
    xfer(CMD_WRITE, 8'h54);
    `CHK("overflow_nack", 1'h1, nack)
    xfer(CMD_STOP, 8'h00);
    rd(REG_STATUS);
    `CHK("no_flag_on_nack", 1'h0, rv[ST_FLAG])
    rd(REG_CTRL1);
    `CHK("overflow_flag", 1'h1, rv[C1_ROVF])
    wr(REG_CTRL1, 8'h01);
    wr(REG_CTRL3, 8'h04);
    xfer(CMD_START, 8'h00);
    xfer(CMD_WRITE, 8'h54);
    `CHK("overwrite_ack", 1'h0, nack)
    xfer(CMD_STOP, 8'h00);
    rd(REG_CTRL1);
    `CHK("overwrite_ovf", 1'h1, rv[C1_ROVF])
    wr(REG_STATUS, 8'h00);
    rd(REG_BUFFER);
    wr(REG_CTRL1, 8'h01);
    $display("test overflow finished");
    wr(REG_CTRL3, 8'h03);
    wr(REG_CTRL2, 8'h01);
    xfer(CMD_START, 8'h00);
    send(CMD_WRITE, 8'h54);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    `CHK("acktime_before", 1'h1, rv[ST_ACKNOWLEDGE_TIME_STATUS])
    rd(REG_CTRL1);
    `CHK("hold_addr", 2'h0, {rv[C1_CKP], link.scl})
    wr(REG_STATUS, 8'h00);
    rd(REG_BUFFER);
    wr(REG_CTRL1, 8'h01);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    `CHK("acktime_after", 1'h0, rv[ST_ACKNOWLEDGE_TIME_STATUS])
    rd(REG_CTRL1);
    `CHK("stretch_after_ack", 1'h0, rv[C1_CKP])
    wr(REG_STATUS, 8'h00);
    wr(REG_CTRL1, 8'h01);
    wait_done();
    `CHK("soft_ack", 1'h0, nack)
    send(CMD_WRITE, 8'h3C);
    poll(REG_STATUS, ST_FLAG, 1'h1);
    wr(REG_STATUS, 8'h00);
    rd(REG_BUFFER);
    `CHK("hold_data", 8'h3C, rv)
    wr(REG_CTRL2, 8'h03);
    wr(REG_CTRL1, 8'h01);
    wait_done();
    `CHK("soft_nack", 1'h1, nack)
    xfer(CMD_STOP, 8'h00);
    wr(REG_CTRL3, 8'h00);
    $display("test hold finished");
    wr(REG_CTRL2, 8'h04);
    wr(REG_BUFFER, 8'hC3);
    `CHK("ack_drive", 2'h3, {link.dev_scl_oe, link.dev_sda_oe})
    poll(REG_CTRL2, C2_ACKNOWLEDGE_SEQUENCE_ENABLE, 1'h0);
    `CHK("scl_kept_low", 1'h0, link.scl)
    rd(REG_CTRL1);
    `CHK("collide_ack", 1'h1, rv[C1_WRITE_COLLISION_FLAG])
    rd(REG_BUFFER);
    `CHK("buffer_kept_ack", 8'h3C, rv)
    wr(REG_CTRL1, 8'h01);
    wr(REG_STATUS, 8'h00);
    wr(REG_CTRL2, 8'h08);
    wr(REG_BUFFER, 8'h99);
    poll(REG_CTRL2, C2_PEN, 1'h0);
    rd(REG_STATUS);
    `CHK("stop_flag", 2'h3, {rv[ST_STOP], rv[ST_FLAG]})
    `CHK("bus_released", 2'h3, {link.scl, link.sda})
    rd(REG_CTRL1);
    `CHK("collide_stop", 1'h1, rv[C1_WRITE_COLLISION_FLAG])
    rd(REG_BUFFER);
    `CHK("buffer_kept_stop", 8'h3C, rv)
    $display("test master sequences finished");
    complete_run();
  end
endmodule
